/* File: design/slf_framer.sv */
// Sensor log packet framer: builds ASCII report frames into a byte FIFO.
// Assumes a byte-wide serial transmitter drains tx_data with valid/ready and that
// the record source on the same clock presents record rec_idx on the rec_ ports.
// What this block does
// - A frame goes out as 'A', attribute, comma, length, comma, data, '$', newline.
// - The attribute byte is '1' for alarm, '2' for switch and '3' for level-compare events.
// - The four-character length field equals the number of data bytes that follow.
// - The data layout follows the attribute; attribute 3 carries one record only.
// - The sample count is sent as two ASCII decimal digits.
// - The elapsed time is sent as ten ASCII decimal digits.
// - Light and temperature readings are each four ASCII decimal digits.
// - Fields and the time are separated by commas, light from temperature by a slash.
// - Without a real-time counter the time and its comma are left out and the length shrinks.
`timescale 1ns/1ps
module slf_framer #(
	parameter bit HAS_RTC = 1'b1,
	parameter int DEPTH = slf_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic start,
	input wire slf_pkg::slf_attr_t attr,
	input wire logic [slf_pkg::CNT_W-1:0] sample_cnt,
	input wire logic [slf_pkg::TIME_W-1:0] rec_time,
	input wire logic [slf_pkg::ADC_W-1:0] rec_light,
	input wire logic [slf_pkg::ADC_W-1:0] rec_temp,
	output logic [slf_pkg::CNT_W-1:0] rec_idx,
	output logic busy,
	output logic done,
	output slf_pkg::slf_byte_t tx_data,
	output logic tx_valid,
	input wire logic tx_ready
);
	import slf_pkg::*;

	// =========================================================================
	// Binary to BCD, shift-and-add-three
	function automatic logic [39:0] to_bcd(input logic [31:0] v);
		logic [39:0] b;
		b = '0;
		for (int i = 31; i >= 0; i--) begin
			for (int d = 0; d < 10; d++) begin
				if (b[d*4 +: 4] > 4'h4) begin
					b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
				end
			end
			b = {b[38:0], v[i]};
		end
		return b;
	endfunction

	// =========================================================================
	// State and captured request
	slf_state_t st;
	slf_state_t next_st;
	logic [3:0] dig;
	logic [3:0] next_dig;
	slf_attr_t cur_attr;
	logic [CNT_W-1:0] cur_cnt;
	logic [CNT_W-1:0] left;
	logic [TIME_W-1:0] r_time;
	logic [ADC_W-1:0] r_light;
	logic [ADC_W-1:0] r_temp;
	slf_byte_t cur_byte;
	logic rec_load;

	slf_fifo_if #(.W(BYTE_W)) fq ();

	slf_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.f(fq.store)
	);

	// Back-pressure: outside S_IDLE the sequencer only advances on a byte the FIFO accepted.
	wire push = (st != S_IDLE) && fq.wready;
	wire accept = (st == S_IDLE) && start && (attr != 2'h0);
	wire level_ev = (cur_attr == ATTR_LEVEL);
	wire last_dig = (dig == 4'h0);
	wire [LEN_W-1:0] rec_len = HAS_RTC ? REC_LEN_RTC : REC_LEN_NORTC;
	// Count field plus one comma-led record per stored sample.
	wire [LEN_W-1:0] list_len = CNT_FIELD_LEN
		+ LEN_W'(cur_cnt) * (rec_len + LEN_W'(1));
	wire [LEN_W-1:0] len_val = level_ev ? rec_len : list_len;
	wire [31:0] field_val = (st == S_LEN) ? 32'(len_val) :
		(st == S_COUNT) ? 32'(cur_cnt) :
		(st == S_TIME) ? r_time :
		(st == S_LIGHT) ? 32'(r_light) : 32'(r_temp);
	wire [39:0] bcd = to_bcd(field_val);
	// Digit index counts down, so the most significant digit leaves first.
	wire [7:0] digit_byte = {CH_DIGIT_HI, bcd[{dig, 2'b00} +: 4]};
	slf_state_t rec_first;
	assign rec_first = HAS_RTC ? S_TIME : S_LIGHT;
	wire [3:0] rec_first_dig = HAS_RTC ? TIME_DIGITS - 4'h1 : ADC_DIGITS - 4'h1;
	wire more_recs = !level_ev && (left > CNT_W'(1));

	// =========================================================================
	// Byte selection
	always_comb begin
		unique case (st)
			S_START: cur_byte = CH_START;
			S_ATTR: cur_byte = {6'h0c, cur_attr};
			S_COMMA1, S_COMMA2, S_SEP, S_TCOMMA: cur_byte = CH_COMMA;
			S_SLASH: cur_byte = CH_SLASH;
			S_END: cur_byte = CH_END;
			S_LF: cur_byte = CH_LF;
			S_IDLE: cur_byte = CH_LF;
			default: cur_byte = digit_byte;
		endcase
	end

	// =========================================================================
	// Frame sequencer
	always_comb begin
		next_st = st;
		next_dig = dig;
		rec_load = 1'b0;
		if (accept) begin
			next_st = S_START;
		end else if (push) begin
			next_dig = dig - 4'h1;
			unique case (st)
				S_START: next_st = S_ATTR;
				S_ATTR: next_st = S_COMMA1;
				S_COMMA1: begin
					next_st = S_LEN;
					next_dig = LEN_DIGITS - 4'h1;
				end
				S_LEN: next_st = last_dig ? S_COMMA2 : S_LEN;
				S_COMMA2: begin
					rec_load = level_ev;
					next_st = level_ev ? rec_first : S_COUNT;
					next_dig = level_ev ? rec_first_dig : CNT_DIGITS - 4'h1;
				end
				S_COUNT: next_st = !last_dig ? S_COUNT :
					(cur_cnt == '0) ? S_END : S_SEP;
				S_SEP: begin
					rec_load = 1'b1;
					next_st = rec_first;
					next_dig = rec_first_dig;
				end
				S_TIME: next_st = last_dig ? S_TCOMMA : S_TIME;
				S_TCOMMA: begin
					next_st = S_LIGHT;
					next_dig = ADC_DIGITS - 4'h1;
				end
				S_LIGHT: next_st = last_dig ? S_SLASH : S_LIGHT;
				S_SLASH: begin
					next_st = S_TEMP;
					next_dig = ADC_DIGITS - 4'h1;
				end
				S_TEMP: next_st = !last_dig ? S_TEMP : more_recs ? S_SEP : S_END;
				S_END: next_st = S_LF;
				S_LF: next_st = S_IDLE;
				S_IDLE: next_st = S_IDLE;
			endcase
		end
	end

	wire rec_done = push && (st == S_TEMP) && last_dig;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= S_IDLE;
			dig <= 4'h0;
		end else begin
			st <= next_st;
			dig <= next_dig;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cur_attr <= 2'h0;
			cur_cnt <= '0;
			left <= '0;
			rec_idx <= '0;
		end else if (accept) begin
			cur_attr <= attr;
			cur_cnt <= sample_cnt;
			left <= sample_cnt;
			rec_idx <= '0;
		end else if (rec_done && !level_ev) begin
			left <= left - CNT_W'(1);
			rec_idx <= rec_idx + CNT_W'(1);
		end
	end

	// Records are captured once so a source update mid-record cannot tear digits.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r_time <= '0;
			r_light <= '0;
			r_temp <= '0;
		end else if (rec_load) begin
			r_time <= rec_time;
			r_light <= rec_light;
			r_temp <= rec_temp;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			done <= 1'b0;
		end else begin
			done <= push && (st == S_LF);
		end
	end

	assign fq.wdata = cur_byte;
	assign fq.wvalid = (st != S_IDLE);
	assign fq.rready = tx_ready;
	assign tx_data = fq.rdata;
	assign tx_valid = fq.rvalid;
	assign busy = (st != S_IDLE) || fq.rvalid;

	// =========================================================================
	// Checks
	logic [LEN_W-1:0] data_seen;
	always_ff @(posedge mclk) begin
		if (sys_rst || (push && st == S_COMMA2)) begin
			data_seen <= '0;
		end else if (push && st != S_END && st != S_LF) begin
			data_seen <= data_seen + LEN_W'(1);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	start_byte_a: assert property (push && st == S_START
		|-> cur_byte == 8'h41 ##1 st == S_ATTR)
		else $error("frame does not open with start code then attribute");
	frame_tail_a: assert property (push && st == S_END |-> cur_byte == 8'h24 ##1 st == S_LF)
		else $error("end code not followed by linefeed");
	attr_code_a: assert property (push && st == S_ATTR |-> cur_byte == 8'h30 + 8'(cur_attr))
		else $error("attribute byte does not match event");
	data_length_a: assert property (push && st == S_END |-> data_seen == len_val)
		else $error("data byte count differs from length field");
	level_layout_a: assert property (push && st == S_COMMA2 && level_ev |=> st == rec_first)
		else $error("level event frame does not start with a record");
	count_digits_a: assert property ($rose(st == S_COUNT) |-> dig == 4'h1)
		else $error("sample count not two digits");
	time_digits_a: assert property ($rose(st == S_TIME) |-> dig == 4'h9)
		else $error("time not ten digits");
	adc_digits_a: assert property ($rose(st == S_LIGHT || st == S_TEMP) |-> dig == 4'h3)
		else $error("reading not four digits");
	slash_sep_a: assert property (push && st == S_LIGHT && last_dig |=> cur_byte == 8'h2f)
		else $error("light not followed by slash");
	no_rtc_a: assert property (!HAS_RTC |-> st != S_TIME && st != S_TCOMMA)
		else $error("time emitted without real-time counter");
	ascii_digit_a: assert property (push
		&& st inside {S_LEN, S_COUNT, S_TIME, S_LIGHT, S_TEMP}
		|-> cur_byte >= 8'h30 && cur_byte <= 8'h39)
		else $error("numeric field byte is not a decimal digit");
	record_sep_a: assert property (rec_done && more_recs
		|=> st == S_SEP ##0 cur_byte == 8'h2c)
		else $error("stored records not comma separated");
endmodule

/* File: design/slf_pkg.sv */
// Constants and types shared by the sensor log packet framer and its byte FIFO.
// Assumes nothing of its surroundings; the framer and FIFO modules import it, the interface does not.
package slf_pkg;
	// =========================================================================
	// Character codes
	localparam logic [7:0] CH_START = 8'h41;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_SLASH = 8'h2f;
	localparam logic [7:0] CH_END = 8'h24;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [3:0] CH_DIGIT_HI = 4'h3;

	// =========================================================================
	// Attribute codes and widths
	localparam logic [1:0] ATTR_ALARM = 2'h1;
	localparam logic [1:0] ATTR_SWITCH = 2'h2;
	localparam logic [1:0] ATTR_LEVEL = 2'h3;
	localparam int BYTE_W = 8;
	localparam int CNT_W = 7;
	localparam int TIME_W = 32;
	localparam int ADC_W = 12;
	localparam int LEN_W = 12;
	localparam int FIFO_DEPTH = 8;

	// =========================================================================
	// Field sizes in characters
	localparam logic [3:0] LEN_DIGITS = 4'h4;
	localparam logic [3:0] CNT_DIGITS = 4'h2;
	localparam logic [3:0] TIME_DIGITS = 4'ha;
	localparam logic [3:0] ADC_DIGITS = 4'h4;
	localparam logic [LEN_W-1:0] REC_LEN_RTC = 12'h014;
	localparam logic [LEN_W-1:0] REC_LEN_NORTC = 12'h009;
	localparam logic [LEN_W-1:0] CNT_FIELD_LEN = 12'h002;

	typedef logic [1:0] slf_attr_t;
	typedef logic [BYTE_W-1:0] slf_byte_t;

	typedef enum logic [14:0] {
		S_IDLE = 15'h0001,
		S_START = 15'h0002,
		S_ATTR = 15'h0004,
		S_COMMA1 = 15'h0008,
		S_LEN = 15'h0010,
		S_COMMA2 = 15'h0020,
		S_COUNT = 15'h0040,
		S_SEP = 15'h0080,
		S_TIME = 15'h0100,
		S_TCOMMA = 15'h0200,
		S_LIGHT = 15'h0400,
		S_SLASH = 15'h0800,
		S_TEMP = 15'h1000,
		S_END = 15'h2000,
		S_LF = 15'h4000
	} slf_state_t;
endpackage

/* File: design/slf_fifo_if.sv */
// Byte stream carrier between the framer and its output FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface slf_fifo_if #(parameter int W = 8);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;
	modport fill (output wdata, output wvalid, input wready,
		input rdata, input rvalid, output rready);
	modport store (input wdata, input wvalid, output wready,
		output rdata, output rvalid, input rready);
endinterface

/* File: design/slf_fifo.sv */
// Synchronous FIFO of W-bit words, DEPTH deep (a power of two).
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module slf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	slf_fifo_if.store f
);
	import slf_pkg::*;
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	wire empty = (wptr == rptr);
	wire do_wr = f.wvalid && !full;
	wire do_rd = f.rvalid && f.rready;

	assign f.wready = !full;
	assign f.rvalid = !empty;
	assign f.rdata = mem[rptr[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem[wptr[AW-1:0]] <= f.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			if (do_wr) begin
				wptr <= wptr + 1'b1;
			end
			if (do_rd) begin
				rptr <= rptr + 1'b1;
			end
		end
	end
endmodule

/* File: testbench/slf_sink.sv */
// Model of the serial transmitter that drains the framer's byte stream.
// Assumes one clock and the synchronous active-high reset of the framer.
`timescale 1ns/1ps
module slf_sink (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic slow,
	output logic tx_ready
);
	// =========================================================================
	// Ready pacing
	// A slow link takes one byte in four cycles, so the FIFO fills and stalls the sequencer.
	logic [1:0] phase;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign tx_ready = !sys_rst && (!slow || phase == 2'h3);
endmodule

/* File: testbench/slf_framer_bench.sv */
// Self-checking bench: one framer with the time field and one without, fed alike.
// Assumes the record source answers rec_idx at once, as a memory read would.
`timescale 1ns/1ps
module slf_framer_bench;
	import slf_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	slf_attr_t attr = 2'h0;
	logic [CNT_W-1:0] sample_cnt = 7'h00;
	logic slow = 1'b0;
	slf_byte_t got_q[2][$];
	slf_byte_t exp_q[2][$];
	int done_n[2];
	int err_total = 0;
	int comparisons = 0;

	// =========================================================================
	// Record source
	function automatic logic [TIME_W-1:0] f_time(input int k);
		return 32'hffffffff - 32'(k) * 32'h000181cd;
	endfunction
	function automatic logic [ADC_W-1:0] f_light(input int k);
		return 12'h7d0 + 12'(k);
	endfunction
	function automatic logic [ADC_W-1:0] f_temp(input int k);
		return 12'h009 + 12'(k) * 12'h028;
	endfunction

	// =========================================================================
	// Two lanes: index 0 has the time field, index 1 leaves it out
	for (genvar g = 0; g < 2; g++) begin : g_lane
		logic [CNT_W-1:0] idx;
		slf_byte_t data;
		logic valid, ready, busy, done;
		slf_framer #(.HAS_RTC(1'(g == 0)), .DEPTH(FIFO_DEPTH)) dut (
			.mclk(mclk), .sys_rst(sys_rst), .start(start), .attr(attr),
			.sample_cnt(sample_cnt), .rec_time(f_time(int'(idx))),
			.rec_light(f_light(int'(idx))), .rec_temp(f_temp(int'(idx))),
			.rec_idx(idx), .busy(busy), .done(done), .tx_data(data),
			.tx_valid(valid), .tx_ready(ready)
		);
		slf_sink sink (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .tx_ready(ready));
		always @(posedge mclk) begin
			if (valid && ready) begin
				got_q[g].push_back(data);
			end
			if (done) begin
				done_n[g]++;
			end
		end
	end

	initial begin
		forever #50 mclk = ~mclk;
	end

	// =========================================================================
	// Expected frames
	task automatic put_num(input int r, input longint v, input int n);
		longint p = 1;
		repeat (n - 1) p = p * 10;
		repeat (n) begin
			exp_q[r].push_back(8'h30 + 8'((v / p) % 10));
			p = p / 10;
		end
	endtask
	task automatic put_rec(input int r, input int k);
		if (r == 0) begin
			put_num(r, longint'(f_time(k)), 10);
			exp_q[r].push_back(CH_COMMA);
		end
		put_num(r, longint'(f_light(k)), 4);
		exp_q[r].push_back(CH_SLASH);
		put_num(r, longint'(f_temp(k)), 4);
	endtask
	task automatic build(input int r, input slf_attr_t a, input int n);
		int rl;
		rl = (r == 0) ? 20 : 9;
		exp_q[r] = {};
		exp_q[r].push_back(CH_START);
		exp_q[r].push_back(8'h30 + 8'(a));
		exp_q[r].push_back(CH_COMMA);
		put_num(r, (a == ATTR_LEVEL) ? rl : 2 + n * (rl + 1), 4);
		exp_q[r].push_back(CH_COMMA);
		if (a == ATTR_LEVEL) begin
			put_rec(r, 0);
		end else begin
			put_num(r, n, 2);
			for (int k = 0; k < n; k++) begin
				exp_q[r].push_back(CH_COMMA);
				put_rec(r, k);
			end
		end
		exp_q[r].push_back(CH_END);
		exp_q[r].push_back(CH_LF);
	endtask

	// =========================================================================
	// Checking and closing
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// =========================================================================
	// Scenarios
	// A second start in mid-frame must be ignored, so each frame also tests refusal.
	task automatic run_frame(input string name, input slf_attr_t a, input int n, input logic s);
		int t;
		build(0, a, n);
		build(1, a, n);
		got_q[0] = {};
		got_q[1] = {};
		done_n[0] = 0;
		done_n[1] = 0;
		@(posedge mclk);
		start <= 1'b1;
		attr <= a;
		sample_cnt <= 7'(n);
		slow <= s;
		@(posedge mclk);
		start <= 1'b0;
		repeat (3) @(posedge mclk);
		start <= 1'b1;
		attr <= (a == ATTR_SWITCH) ? ATTR_ALARM : ATTR_SWITCH;
		@(posedge mclk);
		start <= 1'b0;
		t = 0;
		while ((g_lane[0].busy !== 1'b0 || g_lane[1].busy !== 1'b0) && t < 5000) begin
			@(posedge mclk);
			t++;
		end
		check("frame finished", 32'(t < 5000), 32'h1);
		repeat (2) @(posedge mclk);
		for (int r = 0; r < 2; r++) begin
			check("frame length", got_q[r].size(), exp_q[r].size());
			for (int i = 0; i < exp_q[r].size() && i < got_q[r].size(); i++) begin
				check("frame byte", 32'(got_q[r][i]), 32'(exp_q[r][i]));
			end
			check("done pulses", done_n[r], 1);
		end
		$display("test %s finished", name);
	endtask
	task automatic t_refuse;
		@(posedge mclk);
		start <= 1'b1;
		attr <= 2'h0;
		@(posedge mclk);
		start <= 1'b0;
		repeat (4) @(posedge mclk);
		check("busy after attr 0", 32'(g_lane[0].busy), 32'h0);
		check("valid after attr 0", 32'(g_lane[1].valid), 32'h0);
		$display("test refuse finished");
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check("busy after reset", 32'(g_lane[0].busy), 32'h0);
		run_frame("level_fast", ATTR_LEVEL, 0, 1'b0);
		run_frame("alarm_slow", ATTR_ALARM, 2, 1'b1);
		run_frame("switch_ten", ATTR_SWITCH, 10, 1'b1);
		run_frame("switch_empty", ATTR_SWITCH, 0, 1'b0);
		run_frame("level_slow", ATTR_LEVEL, 5, 1'b1);
		t_refuse;
		wrap_up;
	end

	initial begin
		#3000000;
		err_total++;
		wrap_up;
	end
endmodule
